// [src/sdmtc_bank.sv]
`include "sdmtc_regs.svh"
module sdmtc_bank (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    // timing inputs
    input  wire logic                 hv_free_run,
    input  wire logic                 ext_line_wrap,
    input  wire logic                 ext_frame_wrap,
    // output format controls
    output logic                      noninterlaced_en,
    output logic [1:0]                input_width_sel,
    output logic                      dnr_en,
    output logic                      gamma_en,
    output logic                      gamma_curve_b,
    // level and delay controls
    output logic [1:0]                undershoot_sel,
    output logic                      black_burst_en,
    output sdmtc_pkg::sdmtc_cdly_t    chroma_delay_sel,
    // sync role controls
    output sdmtc_pkg::sdmtc_role_t    timing_role,
    output sdmtc_pkg::sdmtc_tmode_t   timing_mode,
    // video counters
    output logic [9:0]                h_count,
    output logic [9:0]                v_count,
    output logic                      frame_start
);
    import sdmtc_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] fmt_q;
    logic [7:0] lvl_q;
    logic [7:0] role_q;
    logic [7:0] fmt_act_q;
    logic [7:0] lvl_act_q;
    logic [7:0] role_act_q;
    logic [7:0] rdata_d;
    logic [3:0] pix_div_q;
    logic       pix_tick;
    logic       load_act;
    logic       wr_fmt;
    logic       wr_lvl;
    logic       wr_role;

    assign wr_fmt  = reg_wr && reg_addr == `SDMTC_ADDR_FMT;
    assign wr_lvl  = reg_wr && reg_addr == `SDMTC_ADDR_LVL;
    assign wr_role = reg_wr && reg_addr == `SDMTC_ADDR_ROLE;

    // ----------------------------------------------------------------
    // software-visible registers
    // ----------------------------------------------------------------
    // reserved bits are stored and read back but never decoded
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fmt_q <= `SDMTC_RST_FMT;
        end else if (wr_fmt) begin
            fmt_q <= reg_wdata;
        end
    end

    // host keeps reserved bits zero; hardware does not depend on it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lvl_q <= `SDMTC_RST_LVL;
        end else if (wr_lvl) begin
            lvl_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            role_q <= `SDMTC_RST_ROLE;
        end else if (wr_role) begin
            role_q <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            `SDMTC_ADDR_FMT:  rdata_d = fmt_q;
            `SDMTC_ADDR_LVL:  rdata_d = lvl_q;
            `SDMTC_ADDR_ROLE: rdata_d = role_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    // data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // pixel rate divider
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pix_div_q <= 4'h0;
        end else if (pix_div_q == `SDMTC_PIX_DIV - 4'h1) begin
            pix_div_q <= 4'h0;
        end else begin
            pix_div_q <= pix_div_q + 4'h1;
        end
    end

    assign pix_tick = (pix_div_q == `SDMTC_PIX_DIV - 4'h1);

    // ----------------------------------------------------------------
    // horizontal and vertical counters
    // ----------------------------------------------------------------
    sdmtc_hv_counter u_hv (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .pix_tick       (pix_tick),
        .free_run       (hv_free_run),
        .ext_line_wrap  (ext_line_wrap),
        .ext_frame_wrap (ext_frame_wrap),
        .h_count        (h_count),
        .v_count        (v_count),
        .frame_start    (frame_start)
    );

    // ----------------------------------------------------------------
    // active copies
    // ----------------------------------------------------------------
    // with double buffering on, changes land only at a frame start so a
    // picture is never processed with half-updated settings
    assign load_act = !fmt_q[`SDMTC_FMT_DBUF] || frame_start;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fmt_act_q <= `SDMTC_RST_FMT;
        end else if (load_act) begin
            fmt_act_q <= fmt_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lvl_act_q <= `SDMTC_RST_LVL;
        end else if (load_act) begin
            lvl_act_q <= lvl_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            role_act_q <= `SDMTC_RST_ROLE;
        end else if (load_act) begin
            role_act_q <= role_q;
        end
    end

    // reserved code 3 falls back to no delay
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chroma_delay_sel <= SDMTC_CDLY_OFF;
        end else if (load_act) begin
            case (lvl_q[`SDMTC_LVL_CD_HI:`SDMTC_LVL_CD_LO])
                2'h1:    chroma_delay_sel <= SDMTC_CDLY_4;
                2'h2:    chroma_delay_sel <= SDMTC_CDLY_8;
                default: chroma_delay_sel <= SDMTC_CDLY_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    assign noninterlaced_en = fmt_act_q[`SDMTC_FMT_NONINT];
    assign input_width_sel  = fmt_act_q[`SDMTC_FMT_INW_HI:`SDMTC_FMT_INW_LO];
    assign dnr_en           = fmt_act_q[`SDMTC_FMT_DNR];
    assign gamma_en         = fmt_act_q[`SDMTC_FMT_GAMMA_EN];
    assign gamma_curve_b    = fmt_act_q[`SDMTC_FMT_GAMMA_B];
    assign undershoot_sel   = lvl_act_q[`SDMTC_LVL_US_HI:`SDMTC_LVL_US_LO];
    assign black_burst_en   = lvl_act_q[`SDMTC_LVL_BB];
    assign timing_role      = sdmtc_role_t'(role_act_q[`SDMTC_ROLE_MASTER]);
    assign timing_mode      = sdmtc_tmode_t'(role_act_q[`SDMTC_ROLE_MODE_HI:`SDMTC_ROLE_MODE_LO]);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    read_fmt_a: assert property (reg_rd && reg_addr == `SDMTC_ADDR_FMT |=> reg_rdata == $past(fmt_q))
        else $error("read of 0x88 returned wrong data");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read strobe");
    read_lvl_a: assert property (reg_rd && reg_addr == `SDMTC_ADDR_LVL |=> reg_rdata == $past(lvl_q))
        else $error("read of 0x89 returned wrong data");
    read_role_a: assert property (reg_rd && reg_addr == `SDMTC_ADDR_ROLE |=> reg_rdata == $past(role_q))
        else $error("read of 0x8a returned wrong data");
    unmapped_wr_a: assert property (reg_wr && !wr_fmt && !wr_lvl && !wr_role
        |=> $stable(fmt_q) && $stable(lvl_q) && $stable(role_q))
        else $error("write to unmapped address changed a register");
    role_reset_a: assert property (!$past(rst_n) |-> role_q == 8'h08 && timing_role == SDMTC_SLAVE)
        else $error("timing register reset value wrong");
    gamma_apply_a: assert property (wr_fmt && !fmt_q[`SDMTC_FMT_DBUF] ##1 !fmt_q[`SDMTC_FMT_DBUF]
        |=> gamma_en == $past(reg_wdata[`SDMTC_FMT_GAMMA_EN], 2)
            && gamma_curve_b == $past(reg_wdata[`SDMTC_FMT_GAMMA_B], 2))
        else $error("gamma controls not applied from 0x88");
    dnr_apply_a: assert property (wr_fmt && !fmt_q[`SDMTC_FMT_DBUF] ##1 !fmt_q[`SDMTC_FMT_DBUF]
        |=> dnr_en == $past(reg_wdata[`SDMTC_FMT_DNR], 2))
        else $error("noise reduction control not applied");
    burst_apply_a: assert property (wr_lvl && !fmt_q[`SDMTC_FMT_DBUF] ##1 !fmt_q[`SDMTC_FMT_DBUF]
        |=> black_burst_en == $past(reg_wdata[`SDMTC_LVL_BB], 2))
        else $error("black burst control not applied");
    mode_apply_a: assert property (wr_role && !fmt_q[`SDMTC_FMT_DBUF] ##1 !fmt_q[`SDMTC_FMT_DBUF]
        |=> timing_mode == sdmtc_tmode_t'($past(reg_wdata[2:1], 2))
            && timing_role == sdmtc_role_t'($past(reg_wdata[0], 2)))
        else $error("timing role or mode not applied");
    dbuf_hold_a: assert property (fmt_q[`SDMTC_FMT_DBUF] && !frame_start |=> $stable(lvl_act_q))
        else $error("double buffered setting changed mid frame");
    chroma_rsvd_a: assert property (load_act && lvl_q[`SDMTC_LVL_CD_HI:`SDMTC_LVL_CD_LO] == 2'h3
        |=> chroma_delay_sel == SDMTC_CDLY_OFF)
        else $error("reserved chroma delay code reached output");
    curve_hold_a: assert property (!fmt_q[`SDMTC_FMT_DBUF] |=> gamma_curve_b == $past(fmt_q[`SDMTC_FMT_GAMMA_B]))
        else $error("gamma curve output disagrees with stored setting");
endmodule

// [src/sdmtc_regs.svh]
`ifndef SDMTC_REGS_SVH
`define SDMTC_REGS_SVH
// Operation
// - gamma correction applies only while the gamma enable bit of 0x88 is set.
// - curve select bit 7 of 0x88 picks curve A at 0, curve B at 1.
// - noise reduction bit of 0x88 enables at 1, bypasses at 0.
// - black burst on luma output follows the black-burst bit of 0x89.
// - counter mode 0 wraps counters at line, field and frame ends automatically; the counters here wrap at line and frame ends only.
// - counter mode 1 runs counters freely, wrapping only on external sync.
// - 0x8a resets to 0x08; bit 0 slave/master, bits 2:1 timing mode, bit 3 reserved.

// ----------------------------------------------------------------
// register addresses and reset values
// ----------------------------------------------------------------
`define SDMTC_ADDR_FMT       8'h88
`define SDMTC_ADDR_LVL       8'h89
`define SDMTC_ADDR_ROLE      8'h8a
`define SDMTC_RST_FMT        8'h00
`define SDMTC_RST_LVL        8'h00
`define SDMTC_RST_ROLE       8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SDMTC_FMT_NONINT     1
`define SDMTC_FMT_DBUF       2
`define SDMTC_FMT_INW_LO     3
`define SDMTC_FMT_INW_HI     4
`define SDMTC_FMT_DNR        5
`define SDMTC_FMT_GAMMA_EN   6
`define SDMTC_FMT_GAMMA_B    7
`define SDMTC_LVL_US_LO      0
`define SDMTC_LVL_US_HI      1
`define SDMTC_LVL_BB         3
`define SDMTC_LVL_CD_LO      4
`define SDMTC_LVL_CD_HI      5
`define SDMTC_ROLE_MASTER    0
`define SDMTC_ROLE_MODE_LO   1
`define SDMTC_ROLE_MODE_HI   2

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SDMTC_PIX_DIV        4'h4
`define SDMTC_H_TOTAL        10'h35a
`define SDMTC_V_TOTAL        10'h20d
`endif

// [src/sdmtc_pkg.sv]
package sdmtc_pkg;
    typedef enum logic [1:0] {SDMTC_TMODE_0, SDMTC_TMODE_1, SDMTC_TMODE_2, SDMTC_TMODE_3} sdmtc_tmode_t;
    typedef enum logic [1:0] {SDMTC_CDLY_OFF, SDMTC_CDLY_4, SDMTC_CDLY_8} sdmtc_cdly_t;
    typedef enum logic {SDMTC_SLAVE, SDMTC_MASTER} sdmtc_role_t;
endpackage

// [src/sdmtc_hv_counter.sv]
`include "sdmtc_regs.svh"
module sdmtc_hv_counter (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       pix_tick,
    input  wire logic       free_run,
    input  wire logic       ext_line_wrap,
    input  wire logic       ext_frame_wrap,
    // counters
    output logic [9:0]      h_count,
    output logic [9:0]      v_count,
    output logic            frame_start
);
    import sdmtc_pkg::*;

    logic h_end;
    logic v_end;
    logic line_wrap;
    logic frame_wrap;

    assign h_end      = (h_count == `SDMTC_H_TOTAL - 10'h001);
    assign v_end      = (v_count == `SDMTC_V_TOTAL - 10'h001);
    // external sync acts on its own pulse, auto wrap waits for a pixel tick
    assign frame_wrap = free_run ? ext_frame_wrap : (pix_tick && h_end && v_end);
    assign line_wrap  = free_run ? ext_line_wrap : (pix_tick && h_end);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            h_count <= 10'h000;
        end else if (line_wrap || frame_wrap) begin
            h_count <= 10'h000;
        end else if (pix_tick && h_count != 10'h3ff) begin
            // saturate rather than roll over while waiting for external sync
            h_count <= h_count + 10'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            v_count <= 10'h000;
        end else if (frame_wrap) begin
            v_count <= 10'h000;
        end else if (line_wrap && v_count != 10'h3ff) begin
            v_count <= v_count + 10'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            frame_start <= 1'b0;
        end else begin
            frame_start <= frame_wrap;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    auto_line_wrap_a: assert property (!free_run && pix_tick && h_end |=> h_count == 10'h000)
        else $error("auto mode line did not wrap");
    free_hold_a: assert property (free_run && !ext_line_wrap && !ext_frame_wrap && h_count != 10'h3ff && pix_tick
        |=> h_count == $past(h_count) + 10'h001)
        else $error("free run counter wrapped without sync");
    ext_frame_a: assert property (free_run && ext_frame_wrap |=> v_count == 10'h000 && h_count == 10'h000 && frame_start)
        else $error("external frame sync ignored");
endmodule

// [dv/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdmtc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [7:0] o;} sdmtc_row_t;
    logic         core_clk = 1'h0;
    logic         rst_n, reg_wr, reg_rd, hv_free_run, ext_line_wrap, ext_frame_wrap;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, rv;
    logic         noninterlaced_en, dnr_en, gamma_en, gamma_curve_b, black_burst_en, frame_start;
    logic [1:0]   input_width_sel, undershoot_sel;
    sdmtc_cdly_t  chroma_delay_sel;
    sdmtc_role_t  timing_role;
    sdmtc_tmode_t timing_mode;
    logic [9:0]   h_count, v_count, v0;
    int           error_cnt = 0;
    int           n_compared = 0;
    // reserved bits of 0x89 always written as zero
    sdmtc_row_t   rows [16] = '{
        '{8'h88, 8'h40, 8'h40, 8'h40}, '{8'h88, 8'hc0, 8'hc0, 8'hc0}, '{8'h88, 8'h20, 8'h20, 8'h20},
        '{8'h88, 8'h19, 8'h19, 8'h18}, '{8'h88, 8'h02, 8'h02, 8'h02}, '{8'h88, 8'h80, 8'h80, 8'h80},
        '{8'h89, 8'h08, 8'h08, 8'h08}, '{8'h89, 8'h13, 8'h13, 8'h13}, '{8'h89, 8'h20, 8'h20, 8'h20},
        '{8'h89, 8'h30, 8'h30, 8'h00}, '{8'h8a, 8'h01, 8'h01, 8'h01}, '{8'h8a, 8'h02, 8'h02, 8'h02},
        '{8'h8a, 8'h04, 8'h04, 8'h04}, '{8'h8a, 8'h06, 8'h06, 8'h06}, '{8'h8a, 8'hf8, 8'hf8, 8'h00},
        '{8'h88, 8'h00, 8'h00, 8'h00}};

    always #10 core_clk = ~core_clk;

    sdmtc_bank sdmtc_bank_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hv_free_run(hv_free_run),
        .ext_line_wrap(ext_line_wrap), .ext_frame_wrap(ext_frame_wrap), .noninterlaced_en(noninterlaced_en),
        .input_width_sel(input_width_sel), .dnr_en(dnr_en), .gamma_en(gamma_en), .gamma_curve_b(gamma_curve_b),
        .undershoot_sel(undershoot_sel), .black_burst_en(black_burst_en), .chroma_delay_sel(chroma_delay_sel),
        .timing_role(timing_role), .timing_mode(timing_mode), .h_count(h_count), .v_count(v_count),
        .frame_start(frame_start));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // control outputs packed at the bit places of their register, reserved places zero
    function automatic logic [7:0] obs(input logic [7:0] a);
        case (a)
            8'h88: obs = {gamma_curve_b, gamma_en, dnr_en, input_width_sel, 1'h0, noninterlaced_en, 1'h0};
            8'h89: obs = {2'h0, chroma_delay_sel, black_burst_en, 1'h0, undershoot_sel};
            default: obs = {5'h00, timing_mode, timing_role};
        endcase
    endfunction

    task automatic stop_test;
        $display("compared %0d, mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'h0;
    endtask

    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'h0;
        #1 d = reg_rdata;
    endtask

    // kind 0 waits for h_count == val, kind 1 for frame_start
    // looks before each edge, so a one-cycle pulse launched just now is not missed
    task automatic wait_for(input int kind, input logic [9:0] val, input int lim);
        for (int i = 0; i <= lim; i++) begin
            #1;
            if ((kind == 0 && h_count === val) || (kind == 1 && frame_start === 1'h1)) return;
            @(posedge core_clk);
        end
        error_cnt++;
        $display("[ERR] t=%0t wait ran out, kind=%h", $time, kind);
        stop_test;
    endtask

    task automatic pulse(input logic frame);
        @(posedge core_clk);
        ext_line_wrap  <= ~frame;
        ext_frame_wrap <= frame;
        @(posedge core_clk);
        ext_line_wrap  <= 1'h0;
        ext_frame_wrap <= 1'h0;
    endtask

    task automatic reset_check;
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            rd(8'h88 + i[7:0], rv);
            cmp8(rv, (i == 2) ? 8'h08 : 8'h00);
            cmp8(obs(8'h88 + i[7:0]), 8'h00);
        end
        $display("reset test done");
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, hv_free_run, ext_line_wrap, ext_frame_wrap} = 6'h00;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reset_check;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            repeat (2) @(posedge core_clk);
            #1 cmp8(obs(rows[i].a), rows[i].o);
            rd(rows[i].a, rv);
            cmp8(rv, rows[i].r);
        end
        $display("row test done");
        // unmapped places are ignored and read as zero
        wr(8'h8b, 8'hff);
        rd(8'h8b, rv);
        cmp8(rv, 8'h00);
        rd(8'h87, rv);
        cmp8(rv, 8'h00);
        // write then read with no gap, data gone one cycle later
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, 8'h89, 8'h08};
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 cmp8(reg_rdata, 8'h08);
        @(posedge core_clk);
        #1 cmp8(reg_rdata, 8'h00);
        $display("bus test done");
        // auto mode: line end wraps h and steps v
        wait_for(0, 10'h359, 5000);
        v0 = v_count;
        wait_for(0, 10'h000, 8);
        cmp10(v_count, v0 + 10'h001);
        // free mode: no wrap at line end, only on external sync
        @(posedge core_clk);
        hv_free_run <= 1'h1;
        wait_for(0, 10'h35a, 5000);
        v0 = v_count;
        pulse(1'h0);
        wait_for(0, 10'h000, 3);
        cmp10(v_count, v0 + 10'h001);
        pulse(1'h1);
        wait_for(1, 10'h000, 4);
        cmp10(v_count, 10'h000);
        $display("counter test done");
        // double buffering: new gamma setting waits for the frame wrap
        wr(8'h88, 8'h04);
        wr(8'h88, 8'h44);
        repeat (3) @(posedge core_clk);
        #1 cmp8(obs(8'h88), 8'h00);
        pulse(1'h1);
        wait_for(1, 10'h000, 4);
        repeat (2) @(posedge core_clk);
        #1 cmp8(obs(8'h88), 8'h40);
        $display("buffer test done");
        reset_check;
        stop_test;
    end
endmodule
